/* File: mmi_checker.sv */
// Concurrent checks on the ports of mmi_top.
// Bound to every mmi_top instance; one aclk domain, aresetn active low.
`timescale 1ns/1ps
module mmi_checker
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic input_request,
   input wire logic sync_out,
   input wire logic out_valid
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ==========================================
   // Sync and pacing
   a_sync_single:
   assert property (sync_out |=> !sync_out)
      else $error("sync pulse longer than one cycle");
   a_req_spacing:
   assert property (input_request |=> !input_request [*3])
      else $error("input requests closer than four clocks");
   a_out_after_req:
   assert property (out_valid |-> $past(input_request))
      else $error("output word without a request one cycle before");
   // ==========================================
   // Register bus
   a_bvalid_holds:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before it was taken");
   a_rdata_holds:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before it was taken");
   a_write_blocked:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write accepted while a response is pending");
   a_read_blocked:
   assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("new read accepted while read data is pending");
   a_resp_drops:
   assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated after it was taken");
endmodule
bind mmi_top mmi_checker chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .input_request(input_request), .sync_out(sync_out),
   .out_valid(out_valid));

/* File: mmi_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Single clock; synchronous active-low reset.
`timescale 1ns/1ps
module mmi_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge aclk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* File: mmi_pacer.sv */
// Symbol pacer: one input request every 4N or 8N clocks.
// Ratio comes from a register; restarts on the shared sync.
`timescale 1ns/1ps
module mmi_pacer
   import mmi_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [MMI_RATIO_W-1:0] interp_ratio,
   input wire logic double_rate,
   input wire logic sync,
   output logic symbol_tick
);
   logic [15:0] count;
   logic [15:0] period;

   assign period = double_rate
      ? 16'(interp_ratio) * 16'(MMI_DOUBLE_CLOCKS)
      : 16'(interp_ratio) * 16'(MMI_SYMBOL_CLOCKS);

   always_ff @(posedge aclk)
   begin
      if (!aresetn || sync)
      begin
         count <= '0;
         symbol_tick <= 1'b0;
      end
      else
      begin
         // Zero ratio holds the pacer quiet rather than wrapping
         symbol_tick <= (period != 16'h0000) && (count == period - 16'h0001);
         if (period == 16'h0000 || count >= period - 16'h0001)
         begin
            count <= '0;
         end
         else
         begin
            count <= count + 16'h0001;
         end
      end
   end
endmodule

/* File: mmi_pkg.sv */
// Constants, register map and gain constants for the modulator init block.
// Assumes a 20 MHz aclk and an AXI4-Lite register master.
//
// Contract
// - Single-rate input takes one pair per 4N clocks
// - Level scales by rms, gain, shaping tap total
// - Interpolator scales N cubed times shift power
// - Sum attenuation two divides summed output by four
// - Writing E5 then 65 fires one-shot sync
// - Coefficient select 02 uses downloaded shaping taps
// - Page select upper nibble page, low nibble 8
// - Sum chain 0A clear, 02 add, 82 round
// - Double-rate input takes one pair per 8N clocks
package mmi_pkg;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] MMI_SYNC_CONTROL = 8'h00;
   localparam logic [7:0] MMI_COEFFICIENT_SELECT = 8'h04;
   localparam logic [7:0] MMI_SUM_CHAIN_CONTROL = 8'h34;
   localparam logic [7:0] MMI_PAGE_SELECT = 8'h38;
   localparam logic [7:0] MMI_READBACK_STATUS = 8'h3C;
   localparam logic [7:0] MMI_GAIN_CONTROL = 8'h40;
   localparam logic [7:0] MMI_INTERP_CONTROL = 8'h44;
   localparam logic [7:0] MMI_SHAPING_TAP_TOTAL = 8'h48;
   localparam logic [7:0] MMI_MODE_CONTROL = 8'h4C;
   // Printed indices kept for reference
   localparam logic [7:0] MMI_IDX_SYNC = 8'h00;
   localparam logic [7:0] MMI_IDX_COEF = 8'h01;
   localparam logic [7:0] MMI_IDX_SUM = 8'h0D;
   localparam logic [7:0] MMI_IDX_PAGE = 8'h0E;
   localparam logic [7:0] MMI_IDX_STATUS = 8'h0F;
   // ==========================================
   // Reset values and codes
   localparam logic [7:0] MMI_SYNC_IDLE = 8'h65;
   localparam logic [7:0] MMI_SYNC_FIRE = 8'hE5;
   localparam logic [7:0] MMI_COEF_DEFAULT = 8'h00;
   localparam logic [7:0] MMI_COEF_DOWNLOADED = 8'h02;
   localparam logic [7:0] MMI_SUM_FIRST = 8'h0A;
   localparam logic [7:0] MMI_SUM_MIDDLE = 8'h02;
   localparam logic [7:0] MMI_SUM_LAST = 8'h82;
   localparam logic [3:0] MMI_PAGE_LOW = 4'h8;
   localparam logic [7:0] MMI_PAGE_RESET = 8'h08;
   localparam logic [7:0] MMI_GAIN_RESET = 8'h38;
   localparam logic [15:0] MMI_INTERP_RESET = 16'h0010;
   localparam logic [16:0] MMI_TAP_TOTAL_RESET = 17'h10000;
   // ==========================================
   // Field positions
   localparam int MMI_FINE_LSB = 0;
   localparam int MMI_COARSE_LSB = 4;
   localparam int MMI_ATTEN_LSB = 8;
   localparam int MMI_RATIO_LSB = 16;
   localparam int MMI_RATIO_W = 11;
   // ==========================================
   // Gain arithmetic shifts
   localparam int MMI_RMS_SHIFT = 15;
   localparam int MMI_GAIN_SHIFT = 7;
   localparam int MMI_TAP_SHIFT = 16;
   localparam int MMI_COARSE_STEP = 12;
   localparam int MMI_SHIFT_BIAS = 3;
   localparam int MMI_OUT_BITS = 14;
   // ==========================================
   // Pacing and buffering
   localparam int MMI_SYMBOL_CLOCKS = 4;
   localparam int MMI_DOUBLE_CLOCKS = 8;
   localparam int MMI_FIFO_DEPTH = 8;
   localparam int MMI_DATA_W = 32;
   localparam int MMI_CLK_NS = 50;
   localparam logic [1:0] MMI_RESP_OKAY = 2'b00;
   localparam logic [1:0] MMI_RESP_DECERR = 2'b11;
endpackage

/* File: mmi_source.sv */
// Symbol source model: offers QPSK pairs on the valid/ready symbol port.
// Assumes the block takes a pair when sym_valid and sym_ready are both high.
`timescale 1ns/1ps
module mmi_source
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic enable,
   input wire logic sym_ready,
   output logic [15:0] sym_i,
   output logic [15:0] sym_q,
   output logic sym_valid
);
   logic [1:0] sym_index;
   // ==========================================
   // Offer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sym_valid <= 1'b0;
         sym_index <= 2'b00;
         sym_i <= 16'h0000;
         sym_q <= 16'h0000;
      end
      else if (sym_valid && !sym_ready)
      begin
         sym_valid <= 1'b1;
      end
      else if (enable)
      begin
         // Magnitude 16384 leaves room for usable gain settings
         sym_valid <= 1'b1;
         sym_i <= sym_index[0] ? 16'hC000 : 16'h4000;
         sym_q <= sym_index[1] ? 16'hC000 : 16'h4000;
         sym_index <= sym_index + 2'b01;
      end
      else
      begin
         // Released lines must not look like the last pair
         sym_valid <= 1'b0;
         sym_i <= ~sym_i;
         sym_q <= ~sym_q;
      end
   end
endmodule

/* File: mmi_top.sv */
// Modulator init and gain path: AXI4-Lite registers, one-shot sync,
// coefficient selection, symbol pacing, gain scaling and sum chain.
// Assumes one aclk domain; sync_in and sum_in come from other chips.
`timescale 1ns/1ps
module mmi_top
   import mmi_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] sym_i,
   input wire logic [15:0] sym_q,
   input wire logic sym_valid,
   output logic sym_ready,
   output logic input_request,
   input wire logic sync_in,
   output logic sync_out,
   input wire logic [15:0] sum_in,
   output logic [15:0] sum_out,
   output logic [15:0] out_i,
   output logic [15:0] out_q,
   output logic out_valid,
   output logic use_downloaded
);
   // ==========================================
   // Registers
   logic [7:0] sync_control;
   logic [7:0] coefficient_select;
   logic [7:0] sum_chain_control;
   logic [7:0] page_select;
   logic [7:0] gain;
   logic [3:0] fine_shift;
   logic [1:0] coarse_interp_shift;
   logic [1:0] sum_atten;
   logic [MMI_RATIO_W-1:0] interp_ratio;
   logic [16:0] shaping_tap_total;
   logic double_rate;
   logic sync_seen;
   logic page_error;

   // ==========================================
   // Bus slave
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic [31:0] rd_word;
   logic rd_hit;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= MMI_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit(aw_addr) ? MMI_RESP_OKAY : MMI_RESP_DECERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic wr_hit(input logic [7:0] a);
      wr_hit = (a == MMI_SYNC_CONTROL) || (a == MMI_COEFFICIENT_SELECT)
         || (a == MMI_SUM_CHAIN_CONTROL) || (a == MMI_PAGE_SELECT)
         || (a == MMI_GAIN_CONTROL) || (a == MMI_INTERP_CONTROL)
         || (a == MMI_SHAPING_TAP_TOTAL) || (a == MMI_MODE_CONTROL);
   endfunction

   // ==========================================
   // Register writes (byte lane 0 unless noted)
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync_control <= MMI_SYNC_IDLE;
         coefficient_select <= MMI_COEF_DEFAULT;
         sum_chain_control <= MMI_SUM_FIRST;
         page_select <= MMI_PAGE_RESET;
         page_error <= 1'b0;
         gain <= MMI_GAIN_RESET;
         fine_shift <= '0;
         coarse_interp_shift <= '0;
         sum_atten <= '0;
         interp_ratio <= MMI_INTERP_RESET[MMI_RATIO_W-1:0];
         shaping_tap_total <= MMI_TAP_TOTAL_RESET;
         double_rate <= 1'b0;
      end
      else if (do_write && w_strb[0])
      begin
         case (aw_addr)
            MMI_SYNC_CONTROL: sync_control <= w_data[7:0];
            MMI_COEFFICIENT_SELECT: coefficient_select <= w_data[7:0];
            MMI_SUM_CHAIN_CONTROL: sum_chain_control <= w_data[7:0];
            MMI_PAGE_SELECT:
            begin
               page_select <= w_data[7:0];
               page_error <= (w_data[3:0] != MMI_PAGE_LOW);
            end
            MMI_GAIN_CONTROL:
            begin
               gain <= w_data[7:0];
               if (w_strb[1])
               begin
                  sum_atten <= w_data[MMI_ATTEN_LSB +: 2];
               end
            end
            MMI_INTERP_CONTROL:
            begin
               fine_shift <= w_data[MMI_FINE_LSB +: 4];
               coarse_interp_shift <= w_data[MMI_COARSE_LSB +: 2];
               if (w_strb[2])
               begin
                  interp_ratio <= w_data[MMI_RATIO_LSB +: MMI_RATIO_W];
               end
            end
            MMI_SHAPING_TAP_TOTAL: shaping_tap_total <= w_data[16:0];
            MMI_MODE_CONTROL: double_rate <= w_data[0];
            default: ;
         endcase
      end
   end

   // ==========================================
   // Reads
   always_comb
   begin
      rd_hit = 1'b1;
      rd_word = '0;
      case (s_axi_araddr)
         MMI_SYNC_CONTROL: rd_word = {24'h000000, sync_control};
         MMI_COEFFICIENT_SELECT: rd_word = {24'h000000, coefficient_select};
         MMI_SUM_CHAIN_CONTROL: rd_word = {24'h000000, sum_chain_control};
         MMI_PAGE_SELECT: rd_word = {24'h000000, page_select};
         MMI_READBACK_STATUS:
            rd_word = {24'h000000, 4'h0, page_error, sym_ready, use_downloaded, sync_seen};
         MMI_GAIN_CONTROL: rd_word = {22'h000000, sum_atten, gain};
         MMI_INTERP_CONTROL:
            rd_word = {5'h00, interp_ratio, 10'h000, coarse_interp_shift, fine_shift};
         MMI_SHAPING_TAP_TOTAL: rd_word = {15'h0000, shaping_tap_total};
         MMI_MODE_CONTROL: rd_word = {31'h00000000, double_rate};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= MMI_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? MMI_RESP_OKAY : MMI_RESP_DECERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================
   // One-shot sync and coefficient switch
   logic sync_meta;
   logic sync_sync;
   logic sync_last;
   logic fire_prev;
   logic sync_rise;

   // Fire bit edge, not level, so leaving E5 in place gives one pulse
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fire_prev <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         fire_prev <= (sync_control == MMI_SYNC_FIRE);
         sync_out <= (sync_control == MMI_SYNC_FIRE) && !fire_prev;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync_meta <= 1'b0;
         sync_sync <= 1'b0;
         sync_last <= 1'b0;
         sync_seen <= 1'b0;
      end
      else
      begin
         sync_meta <= sync_in;
         sync_sync <= sync_meta;
         sync_last <= sync_sync;
         if (sync_rise)
         begin
            sync_seen <= 1'b1;
         end
      end
   end
   assign sync_rise = sync_sync && !sync_last;

   assign use_downloaded = (coefficient_select == MMI_COEF_DOWNLOADED);

   // ==========================================
   // Symbol path through the FIFO
   logic symbol_tick;
   logic [31:0] fifo_data;
   logic fifo_valid;
   logic take;

   mmi_pacer u_pacer
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .interp_ratio(interp_ratio),
      .double_rate(double_rate),
      .sync(sync_rise),
      .symbol_tick(symbol_tick)
   );

   mmi_fifo #(.WIDTH(MMI_DATA_W), .DEPTH(MMI_FIFO_DEPTH)) u_fifo
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_data({sym_i, sym_q}),
      .in_valid(sym_valid),
      .in_ready(sym_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(symbol_tick)
   );

   assign take = symbol_tick && fifo_valid;
   assign input_request = symbol_tick;

   // ==========================================
   // Gain: rms/2^15 * G/2^7 * taps/2^16, then 2^-(fine+12*coarse+3)
   logic signed [47:0] prod_i;
   logic signed [47:0] prod_q;
   logic [5:0] shift_amt;
   logic signed [47:0] scaled_i;
   logic signed [47:0] scaled_q;
   logic signed [47:0] cube;

   // N cubed folded into the product, then shifted down
   assign cube = 48'(interp_ratio) * 48'(interp_ratio) * 48'(interp_ratio);
   assign shift_amt = 6'(fine_shift) + 6'(MMI_COARSE_STEP) * 6'(coarse_interp_shift)
      + 6'(MMI_SHIFT_BIAS);
   assign prod_i = (48'(signed'(fifo_data[31:16])) * signed'(48'(gain))
      * signed'(48'(shaping_tap_total))) >>> (MMI_GAIN_SHIFT + MMI_TAP_SHIFT);
   assign prod_q = (48'(signed'(fifo_data[15:0])) * signed'(48'(gain))
      * signed'(48'(shaping_tap_total))) >>> (MMI_GAIN_SHIFT + MMI_TAP_SHIFT);
   assign scaled_i = 48'((64'(prod_i) * 64'(cube)) >>> shift_amt);
   assign scaled_q = 48'((64'(prod_q) * 64'(cube)) >>> shift_amt);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         out_i <= '0;
         out_q <= '0;
         out_valid <= 1'b0;
      end
      else
      begin
         out_valid <= take;
         if (take)
         begin
            out_i <= scaled_i[15:0];
            out_q <= scaled_q[15:0];
         end
      end
   end

   // ==========================================
   // Sum chain: clear, add cascade, or round last chip
   logic signed [17:0] sum_raw;
   logic signed [17:0] sum_div;
   logic signed [17:0] sum_rnd;

   assign sum_raw = (sum_chain_control == MMI_SUM_FIRST)
      ? 18'(signed'(out_i)) : 18'(signed'(out_i)) + 18'(signed'(sum_in));
   assign sum_div = sum_raw >>> sum_atten;
   assign sum_rnd = (sum_div + 18'sd2) & ~18'sd3;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sum_out <= '0;
      end
      else if (sum_chain_control == MMI_SUM_LAST)
      begin
         sum_out <= sum_rnd[15:0];
      end
      else
      begin
         sum_out <= sum_div[15:0];
      end
   end
endmodule

/* File: multichip_modulator_init_test.sv */
// Testbench for mmi_top: register map, one-shot sync, coefficient select, pacing, FIFO.
// Assumes mmi_source on the symbol port and the bound mmi_checker.
`timescale 1ns/1ps
module multichip_modulator_init_test
   import mmi_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
   logic arready, rvalid, sym_valid, sym_ready, input_request, sync_out, out_valid, src_en, use_dl;
   logic [7:0] awaddr, araddr, rd;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [15:0] sym_i, sym_q, sum_in, sum_out, out_i, out_q;
   int fail_count, tests_run, cycles, accepted, outs, full_seen, pulses, g;
   // Sync output loops to the shared sync input
   mmi_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sym_i(sym_i), .sym_q(sym_q), .sym_valid(sym_valid), .sym_ready(sym_ready),
      .input_request(input_request), .sync_in(sync_out), .sync_out(sync_out), .sum_in(sum_in),
      .sum_out(sum_out), .out_i(out_i), .out_q(out_q), .out_valid(out_valid),
      .use_downloaded(use_dl));
   mmi_source src (.aclk(aclk), .aresetn(aresetn), .enable(src_en), .sym_ready(sym_ready),
      .sym_i(sym_i), .sym_q(sym_q), .sym_valid(sym_valid));
   // ==========================================
   // Shared tasks
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (awvalid && !awready || wvalid && !wready);
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      // Late rready exercises the slave holding its answer
      repeat (2) @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      d = rdata[7:0];
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic gap;
      do @(posedge aclk); while (input_request !== 1'b1);
      g = 0;
      do
      begin
         @(posedge aclk);
         g++;
      end
      while (input_request !== 1'b1);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset_map;
      logic [7:0] ad [4];
      logic [7:0] ex [4];
      ad = '{MMI_SYNC_CONTROL, MMI_COEFFICIENT_SELECT, MMI_SUM_CHAIN_CONTROL, MMI_PAGE_SELECT};
      ex = '{MMI_SYNC_IDLE, MMI_COEF_DEFAULT, MMI_SUM_FIRST, MMI_PAGE_RESET};
      foreach (ad[i])
      begin
         rd_reg(ad[i], rd, resp);
         check("reset value", rd, ex[i]);
      end
      rd_reg(8'h80, rd, resp);
      check("read decode", {6'h00, resp}, {6'h00, MMI_RESP_DECERR});
      wr(8'h80, 32'h0000_00FF, resp);
      check("write decode", {6'h00, resp}, {6'h00, MMI_RESP_DECERR});
      wr(MMI_READBACK_STATUS, 32'h0000_00FF, resp);
      rd_reg(MMI_READBACK_STATUS, rd, resp);
      check("status read only", rd, 8'h04);
   endtask
   task automatic t_sum_page;
      logic [7:0] code [3];
      code = '{MMI_SUM_FIRST, MMI_SUM_MIDDLE, MMI_SUM_LAST};
      foreach (code[i])
      begin
         wr(MMI_SUM_CHAIN_CONTROL, 32'(code[i]), resp);
         rd_reg(MMI_SUM_CHAIN_CONTROL, rd, resp);
         check("sum chain", rd, code[i]);
      end
      wr(MMI_PAGE_SELECT, 32'h0000_0028, resp);
      rd_reg(MMI_PAGE_SELECT, rd, resp);
      check("page", rd, 8'h28);
      wr(MMI_PAGE_SELECT, 32'h0000_0025, resp);
      rd_reg(MMI_READBACK_STATUS, rd, resp);
      check("page nibble flag", {7'h00, rd[3]}, 8'h01);
      wr(MMI_PAGE_SELECT, 32'(MMI_PAGE_RESET), resp);
   endtask
   task automatic t_sync;
      check("early pulses", 8'(pulses), 8'h00);
      wr(MMI_SYNC_CONTROL, 32'(MMI_SYNC_FIRE), resp);
      wr(MMI_SYNC_CONTROL, 32'(MMI_SYNC_IDLE), resp);
      repeat (10) @(posedge aclk);
      check("one-shot pulses", 8'(pulses), 8'h01);
      rd_reg(MMI_READBACK_STATUS, rd, resp);
      check("sync seen", {7'h00, rd[0]}, 8'h01);
   endtask
   task automatic t_coef;
      wr(MMI_COEFFICIENT_SELECT, 32'h0000_0001, resp);
      @(posedge aclk);
      check("other select", {7'h00, use_dl}, 8'h00);
      wr(MMI_COEFFICIENT_SELECT, 32'(MMI_COEF_DOWNLOADED), resp);
      @(posedge aclk);
      check("downloaded select", {7'h00, use_dl}, 8'h01);
      rd_reg(MMI_READBACK_STATUS, rd, resp);
      check("status select", {7'h00, rd[1]}, 8'h01);
   endtask
   task automatic t_pacing;
      wr(MMI_INTERP_CONTROL, 32'h0002_0000, resp);
      gap();
      gap();
      check("single rate gap", 8'(g), 8'(MMI_SYMBOL_CLOCKS * 2));
      wr(MMI_MODE_CONTROL, 32'h0000_0001, resp);
      gap();
      gap();
      check("double rate gap", 8'(g), 8'(MMI_DOUBLE_CLOCKS * 2));
      wr(MMI_MODE_CONTROL, 32'h0000_0000, resp);
   endtask
   task automatic t_fifo;
      src_en <= 1'b1;
      repeat (40) @(posedge aclk);
      src_en <= 1'b0;
      repeat (120) @(posedge aclk);
      check("refused when full", 8'(full_seen != 0), 8'h01);
      check("words out", 8'(outs), 8'(accepted));
      check("ready after drain", {7'h00, sym_ready}, 8'h01);
   endtask
   task automatic t_chain;
      int m, v;
      // Last pair held at the outputs; ratio 2, shifts 0, taps unity
      m = 16384 * int'(MMI_GAIN_RESET) / 128;
      v = ((accepted - 1) % 2) ? -m : m;
      check("out i", out_i, 16'(v));
      check("out q", out_q, ((accepted - 1) / 2 % 2) ? 16'(-m) : 16'(m));
      wr(MMI_SUM_CHAIN_CONTROL, 32'(MMI_SUM_MIDDLE), resp);
      wr(MMI_GAIN_CONTROL, 32'h0000_0238, resp);
      @(posedge aclk);
      check("sum atten", sum_out, 16'((v + 4660) / 4));
      // Odd cascade input so rounding differs from truncation
      sum_in <= 16'h1237;
      wr(MMI_GAIN_CONTROL, 32'h0000_0038, resp);
      wr(MMI_SUM_CHAIN_CONTROL, 32'(MMI_SUM_LAST), resp);
      @(posedge aclk);
      check("sum round", sum_out, 16'(v + 4664));
      wr(MMI_SUM_CHAIN_CONTROL, 32'(MMI_SUM_FIRST), resp);
      @(posedge aclk);
      check("sum clear", sum_out, 16'(v));
   endtask
   // ==========================================
   // Clock, monitors and main sequence
   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (sym_valid && sym_ready)
         accepted <= accepted + 1;
      if (out_valid === 1'b1)
         outs <= outs + 1;
      if (sym_ready === 1'b0 && aresetn)
         full_seen <= full_seen + 1;
      if (sync_out === 1'b1)
         pulses <= pulses + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         print_verdict();
      end
   end
   initial
   begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, src_en} = '0;
      {awaddr, araddr} = '0;
      wdata = 32'h0000_0000;
      wstrb = 4'hF;
      sum_in = 16'h1234;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_map();
      t_sum_page();
      t_sync();
      t_coef();
      t_pacing();
      t_fifo();
      t_chain();
      print_verdict();
   end
endmodule
